// *** rtl/ldr_regfile.sv ***
// register file of the four-channel led driver, reached over the serial bus
//
// Operation
// - the live state code of the functional state machine is readable.
// - the pwm pin duty is measured and readable as a 16-bit value.
// - the applied 16-bit output pwm duty is readable.
// - the applied 12-bit current converter code is readable.
// - the 10-bit adaptive boost target code is readable.
// - dimming mode, phase layout, switching and dimming rate are readable.
// - sixteen 16-bit registers sit at even offsets 00h to 1Eh.
// - the brightness setpoint is 16-bit read/write and resets to zero.
// - the 12-bit current level resets to FFFh and drives all outputs.
// - current register bits 15-12 are read/write and reset to zero.
// - a write is address, offset, then the value in two bytes.
// - a read is address, offset, address with read, then two bytes.
// - a fault flag clears only when its status and clear bits are both 1.
// - each fault has a 2-bit enable: reads 10 when on, 00 off; write 01 off, 11 on.
`timescale 1ns/1ps
`default_nettype none
module ldr_regfile
  import ldr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_addr_sel,
  input wire logic i_pwm_in,
  input wire logic [LDR_FAULTS-1:0] i_supply_fault,
  input wire logic [LDR_FAULTS-1:0] i_boost_fault,
  input wire logic [LDR_FAULTS-1:0] i_led_fault,
  input wire logic [15:0] i_live_state_code,
  input wire logic [15:0] i_applied_output_duty,
  input wire logic [11:0] i_applied_current_code,
  input wire logic [9:0] i_boost_target_code,
  input wire ldr_detect_s i_detected,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [15:0] o_brightness_setpoint,
  output logic [11:0] o_drive_current_level,
  output logic [15:0] o_user_settings_one,
  output logic [15:0] o_user_settings_two,
  output logic [3*LDR_FAULTS-1:0] o_fault_enable,
  output logic [3*LDR_FAULTS-1:0] o_fault_flags
);
  ldr_req_s req;
  logic [15:0] rdata;
  logic [15:0] duty_in;
  logic [3:0] curr_rsvd_q;
  logic [15:0] diag_fsm_q;
  logic [15:0] diag_out_q;
  logic [11:0] diag_curr_q;
  logic [9:0] diag_boost_q;
  ldr_detect_s diag_det_q;

  ////////////////////////////////////////////////////////////////////////////
  ldr_bus_slave u_bus (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_addr_sel(i_addr_sel),
    .i_rdata(rdata),
    .o_req(req),
    .o_sda_oe(o_sda_oe)
  );

  ldr_duty_meter u_duty (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_pwm_in(i_pwm_in),
    .o_duty(duty_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write decode; only the ten writable offsets have strobes
  wire wr_bright = req.we && req.addr == LDR_OFF_BRIGHT;
  wire wr_curr = req.we && req.addr == LDR_OFF_CURR;
  wire wr_user1 = req.we && req.addr == LDR_OFF_USER1;
  wire wr_user2 = req.we && req.addr == LDR_OFF_USER2;
  wire [2:0] wr_en = {req.we && req.addr == LDR_OFF_LED_EN,
                      req.we && req.addr == LDR_OFF_BST_EN,
                      req.we && req.addr == LDR_OFF_SUP_EN};
  wire [2:0] wr_st = {req.we && req.addr == LDR_OFF_LED_ST,
                      req.we && req.addr == LDR_OFF_BST_ST,
                      req.we && req.addr == LDR_OFF_SUP_ST};
  wire [3*LDR_FAULTS-1:0] fault_in = {i_led_fault, i_boost_fault,
                                      i_supply_fault};

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_brightness_setpoint <= LDR_RST_BRIGHT;
      o_drive_current_level <= LDR_RST_CURR;
      curr_rsvd_q <= LDR_RST_CURR_RSVD;
      o_user_settings_one <= LDR_RST_USER1;
      o_user_settings_two <= LDR_RST_USER2;
      o_sda_out <= 1'b0;
    end else begin
      if (wr_bright) o_brightness_setpoint <= req.wdata;
      if (wr_curr) begin
        o_drive_current_level <= req.wdata[11:0];
        curr_rsvd_q <= req.wdata[15:12];
      end
      if (wr_user1) o_user_settings_one <= req.wdata;
      if (wr_user2) o_user_settings_two <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-fault enable and sticky flag, one group per status register
  // next values per bit, one register process keeps a single driver
  wire [3*LDR_FAULTS-1:0] en_d;
  wire [3*LDR_FAULTS-1:0] fl_d;
  genvar g;
  genvar f;
  generate
    for (g = 0; g < 3; g++) begin : g_grp
      for (f = 0; f < LDR_FAULTS; f++) begin : g_flt
        localparam int N = g * LDR_FAULTS + f;
        wire [1:0] en_wr = req.wdata[2*f+1:2*f];
        wire en_on = wr_en[g] && en_wr == LDR_EN_WR_ON;
        wire en_off = wr_en[g] && en_wr == LDR_EN_WR_OFF;
        wire clr = wr_st[g] && req.wdata[2*f] && req.wdata[2*f+1];
        assign en_d[N] = en_on | (o_fault_enable[N] & ~en_off);
        // a fault in the clear cycle stays set
        assign fl_d[N] = fault_in[N] | (o_fault_flags[N] & ~clr);
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_fault_enable <= {3{LDR_RST_FAULT_EN}};
      o_fault_flags <= '0;
    end else begin
      o_fault_enable <= en_d;
      o_fault_flags <= fl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // live copies of the diagnostic sources, one clock behind
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      diag_fsm_q <= 16'h0000;
      diag_out_q <= 16'h0000;
      diag_curr_q <= 12'h000;
      diag_boost_q <= 10'h000;
      diag_det_q <= '0;
    end else begin
      diag_fsm_q <= i_live_state_code;
      diag_out_q <= i_applied_output_duty;
      diag_curr_q <= i_applied_current_code;
      diag_boost_q <= i_boost_target_code;
      diag_det_q <= i_detected;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; reads are pure, diagnostic offsets have no write strobe
  function automatic logic [15:0] en_view(input logic [LDR_FAULTS-1:0] en);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < LDR_FAULTS; i++) begin
      v[2*i+:2] = en[i] ? LDR_EN_RD_ON : 2'h0;
    end
    return v;
  endfunction : en_view

  function automatic logic [15:0] st_view(input logic [LDR_FAULTS-1:0] st);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < LDR_FAULTS; i++) begin
      v[2*i] = st[i];
    end
    return v;
  endfunction : st_view

  wire [15:0] det_word = {2'h0, diag_det_q};
  wire [15:0] en_sup = en_view(o_fault_enable[0+:LDR_FAULTS]);
  wire [15:0] en_bst = en_view(o_fault_enable[LDR_FAULTS+:LDR_FAULTS]);
  wire [15:0] en_led = en_view(o_fault_enable[2*LDR_FAULTS+:LDR_FAULTS]);
  wire [15:0] st_sup = st_view(o_fault_flags[0+:LDR_FAULTS]);
  wire [15:0] st_bst = st_view(o_fault_flags[LDR_FAULTS+:LDR_FAULTS]);
  wire [15:0] st_led = st_view(o_fault_flags[2*LDR_FAULTS+:LDR_FAULTS]);

  always_comb begin
    case (req.addr)
      LDR_OFF_BRIGHT: rdata = o_brightness_setpoint;
      LDR_OFF_CURR: rdata = {curr_rsvd_q, o_drive_current_level};
      LDR_OFF_USER1: rdata = o_user_settings_one;
      LDR_OFF_USER2: rdata = o_user_settings_two;
      LDR_OFF_SUP_EN: rdata = en_sup;
      LDR_OFF_BST_EN: rdata = en_bst;
      LDR_OFF_LED_EN: rdata = en_led;
      LDR_OFF_SUP_ST: rdata = st_sup;
      LDR_OFF_BST_ST: rdata = st_bst;
      LDR_OFF_LED_ST: rdata = st_led;
      LDR_OFF_FSM: rdata = diag_fsm_q;
      LDR_OFF_PWM_IN: rdata = duty_in;
      LDR_OFF_PWM_OUT: rdata = diag_out_q;
      LDR_OFF_CURR_DIAG: rdata = {4'h0, diag_curr_q};
      LDR_OFF_BOOST: rdata = {6'h00, diag_boost_q};
      LDR_OFF_DETECT: rdata = det_word;
      // holes in the map read zero; writes there are dropped
      default: rdata = 16'h0000;
    endcase
  end
endmodule : ldr_regfile
`default_nettype wire

// *** rtl/ldr_pkg.sv ***
// package: offsets, reset values and carriers of the led driver register file
package ldr_pkg;
  localparam logic [7:0] LDR_OFF_BRIGHT = 8'h00;
  localparam logic [7:0] LDR_OFF_CURR = 8'h02;
  localparam logic [7:0] LDR_OFF_USER1 = 8'h04;
  localparam logic [7:0] LDR_OFF_USER2 = 8'h06;
  localparam logic [7:0] LDR_OFF_SUP_EN = 8'h08;
  localparam logic [7:0] LDR_OFF_BST_EN = 8'h0A;
  localparam logic [7:0] LDR_OFF_LED_EN = 8'h0C;
  localparam logic [7:0] LDR_OFF_SUP_ST = 8'h0E;
  localparam logic [7:0] LDR_OFF_BST_ST = 8'h10;
  localparam logic [7:0] LDR_OFF_LED_ST = 8'h12;
  localparam logic [7:0] LDR_OFF_FSM = 8'h14;
  localparam logic [7:0] LDR_OFF_PWM_IN = 8'h16;
  localparam logic [7:0] LDR_OFF_PWM_OUT = 8'h18;
  localparam logic [7:0] LDR_OFF_CURR_DIAG = 8'h1A;
  localparam logic [7:0] LDR_OFF_BOOST = 8'h1C;
  localparam logic [7:0] LDR_OFF_DETECT = 8'h1E;
  localparam logic [15:0] LDR_RST_BRIGHT = 16'h0000;
  localparam logic [11:0] LDR_RST_CURR = 12'hFFF;
  localparam logic [3:0] LDR_RST_CURR_RSVD = 4'h0;
  localparam logic [15:0] LDR_RST_USER1 = 16'h08A3;
  localparam logic [15:0] LDR_RST_USER2 = 16'h0100;
  localparam logic [7:0] LDR_RST_FAULT_EN = 8'hFF;
  localparam int LDR_FAULTS = 8;
  // base bus address, low bit picked by a strap
  localparam logic [6:0] LDR_BUS_ADDR = 7'h3A;
  localparam int LDR_BIT_CNT_DONE = 8;
  // duty window is 2**16 clocks, 6.5536 ms at 10 MHz
  localparam int LDR_DUTY_W = 16;
  localparam logic [1:0] LDR_EN_RD_ON = 2'h2;
  localparam logic [1:0] LDR_EN_WR_OFF = 2'h1;
  localparam logic [1:0] LDR_EN_WR_ON = 2'h3;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ldr_req_s;

  typedef struct packed {
    logic [1:0] dim_mode;
    logic [3:0] phase_layout;
    logic [3:0] switching_rate;
    logic [3:0] dimming_rate;
  } ldr_detect_s;

  typedef enum logic [6:0] {
    LDR_IDLE = 7'h01,
    LDR_ADDR = 7'h02,
    LDR_ACK_A = 7'h04,
    LDR_WRB = 7'h08,
    LDR_ACK_W = 7'h10,
    LDR_RDB = 7'h20,
    LDR_ACK_R = 7'h40
  } ldr_state_e;
endpackage : ldr_pkg

// *** rtl/ldr_duty_meter.sv ***
// duty meter: fraction of high time of the pwm pin over a fixed window
`timescale 1ns/1ps
`default_nettype none
module ldr_duty_meter
  import ldr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_pwm_in,
  output logic [15:0] o_duty
);
  logic [LDR_DUTY_W-1:0] win_q;
  logic [LDR_DUTY_W:0] high_q;
  wire win_end = &win_q;
  wire [LDR_DUTY_W:0] high_inc = high_q + {{LDR_DUTY_W{1'b0}}, i_pwm_in};
  // full-high window would read 10000h; saturate to FFFFh
  wire [15:0] duty_sat = high_inc[LDR_DUTY_W] ? 16'hFFFF
                         : high_inc[15:0];

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      win_q <= '0;
      high_q <= '0;
      o_duty <= 16'h0000;
    end else begin
      win_q <= win_q + 1'b1;
      high_q <= win_end ? '0 : high_inc;
      if (win_end) o_duty <= duty_sat;
    end
  end
endmodule : ldr_duty_meter
`default_nettype wire

// *** rtl/ldr_bus_slave.sv ***
// two-wire serial slave: 4-byte writes, 5-byte reads of 16-bit registers
`timescale 1ns/1ps
`default_nettype none
module ldr_bus_slave
  import ldr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_addr_sel,
  input wire logic [15:0] i_rdata,
  output ldr_req_s o_req,
  output logic o_sda_oe
);
  ldr_state_e state_q;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [1:0] idx_q;
  logic rw_q;
  logic rd_lo_q;
  logic nack_q;
  logic [7:0] lo_q;

  wire rise = i_scl & ~scl_q;
  wire fall = ~i_scl & scl_q;
  wire start = i_scl & scl_q & sda_q & ~i_sda;
  wire stop = i_scl & scl_q & ~sda_q & i_sda;
  wire byte_done = cnt_q == 4'(LDR_BIT_CNT_DONE);
  wire addr_hit = sh_q[7:1] == {LDR_BUS_ADDR[6:1], i_addr_sel};

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_q <= LDR_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      idx_q <= 2'h0;
      rw_q <= 1'b0;
      rd_lo_q <= 1'b0;
      nack_q <= 1'b0;
      lo_q <= 8'h00;
      o_req <= '0;
      o_sda_oe <= 1'b0;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      o_req.we <= 1'b0;
      if (stop) begin
        state_q <= LDR_IDLE;
        o_sda_oe <= 1'b0;
      end else if (start) begin
        // repeated start keeps the offset for the read
        state_q <= LDR_ADDR;
        cnt_q <= 4'h0;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_q)
          LDR_IDLE: ;
          LDR_ADDR, LDR_WRB: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], i_sda};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && byte_done) begin
              cnt_q <= 4'h0;
              if (state_q == LDR_ADDR) begin
                if (addr_hit) begin
                  rw_q <= sh_q[0];
                  o_sda_oe <= 1'b1;
                  state_q <= LDR_ACK_A;
                  if (!sh_q[0]) idx_q <= 2'h0;
                end else begin
                  state_q <= LDR_IDLE;
                end
              end else begin
                o_sda_oe <= idx_q != 2'h3;
                state_q <= LDR_ACK_W;
                case (idx_q)
                  2'h0: o_req.addr <= sh_q;
                  2'h1: o_req.wdata[15:8] <= sh_q;
                  2'h2: begin
                    o_req.wdata[7:0] <= sh_q;
                    o_req.we <= 1'b1;
                  end
                  default: ;
                endcase
                if (idx_q != 2'h3) idx_q <= idx_q + 2'h1;
              end
            end
          end
          LDR_ACK_A: begin
            if (fall) begin
              if (rw_q) begin
                // snapshot both bytes so the pair is coherent
                sh_q <= i_rdata[15:8];
                lo_q <= i_rdata[7:0];
                rd_lo_q <= 1'b0;
                o_sda_oe <= ~i_rdata[15];
                state_q <= LDR_RDB;
              end else begin
                o_sda_oe <= 1'b0;
                state_q <= LDR_WRB;
              end
            end
          end
          LDR_ACK_W: begin
            if (fall) begin
              o_sda_oe <= 1'b0;
              state_q <= LDR_WRB;
            end
          end
          LDR_RDB: begin
            if (rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (fall) begin
              if (byte_done) begin
                cnt_q <= 4'h0;
                o_sda_oe <= 1'b0;
                state_q <= LDR_ACK_R;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                o_sda_oe <= ~sh_q[6];
              end
            end
          end
          LDR_ACK_R: begin
            if (rise) begin
              nack_q <= i_sda;
            end else if (fall) begin
              if (nack_q || rd_lo_q) begin
                state_q <= LDR_IDLE;
              end else begin
                sh_q <= lo_q;
                rd_lo_q <= 1'b1;
                o_sda_oe <= ~lo_q[7];
                state_q <= LDR_RDB;
              end
            end
          end
          default: state_q <= LDR_IDLE;
        endcase
      end
    end
  end
endmodule : ldr_bus_slave
`default_nettype wire

// *** bench/ldr_regfile_properties.sv ***
// checker: port-level properties of the led driver register file
`timescale 1ns/1ps
`default_nettype none
module ldr_regfile_properties
  import ldr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic [LDR_FAULTS-1:0] i_supply_fault,
  input wire logic [LDR_FAULTS-1:0] i_boost_fault,
  input wire logic [LDR_FAULTS-1:0] i_led_fault,
  input wire logic o_sda_oe,
  input wire logic [15:0] o_brightness_setpoint,
  input wire logic [11:0] o_drive_current_level,
  input wire logic [3*LDR_FAULTS-1:0] o_fault_enable,
  input wire logic [3*LDR_FAULTS-1:0] o_fault_flags
);
  wire [3*LDR_FAULTS-1:0] fault_ev;
  assign fault_ev = {i_led_fault, i_boost_fault, i_supply_fault};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////
  // writes commit after an scl fall, so a long high phase is quiet
  sequence scl_high_run;
    i_scl [*3];
  endsequence
  bright_rst_a: assert property (
    $fell(i_reset) |-> o_brightness_setpoint == LDR_RST_BRIGHT)
    else $error("brightness not cleared by reset");
  curr_rst_a: assert property (
    $fell(i_reset) |-> o_drive_current_level == LDR_RST_CURR)
    else $error("current level not full scale after reset");
  fault_rst_a: assert property (
    $fell(i_reset) |-> o_fault_flags == '0 && o_fault_enable == '1)
    else $error("fault flags or enables wrong after reset");
  flag_set_a: assert property (
    |fault_ev |=> (o_fault_flags & $past(fault_ev)) == $past(fault_ev))
    else $error("fault event did not set its flag");
  flag_hold_a: assert property (
    scl_high_run |-> ($past(o_fault_flags) & ~o_fault_flags) == '0)
    else $error("fault flag cleared outside a bus write");
  set_hold_a: assert property (
    scl_high_run |-> $stable(o_brightness_setpoint)
      && $stable(o_drive_current_level))
    else $error("setting changed outside a bus write");
  en_hold_a: assert property (
    scl_high_run |-> $stable(o_fault_enable))
    else $error("fault enable changed outside a bus write");
  sda_change_a: assert property (
    $changed(o_sda_oe) |-> !i_scl && !$past(i_scl))
    else $error("sda drive changed while scl high");
endmodule : ldr_regfile_properties
`default_nettype wire

// *** bench/ldr_host_model.sv ***
// host model: serial bus master issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module ldr_host_model
  import ldr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  logic [6:0] dev_addr;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    dev_addr = LDR_BUS_ADDR;
  end
  ////////////////////////////////////////
  // four clocks per scl level, slave needs three
  task automatic tick();
    repeat (4) @(negedge i_core_clk);
  endtask : tick
  // b high releases the line, so the same slot samples the slave
  task automatic bit_io(input logic b, output logic s);
    o_sda_oe = !b;
    tick();
    o_scl = 1'b1;
    s = i_sda;
    tick();
    o_scl = 1'b0;
  endtask : bit_io
  task automatic start();
    o_sda_oe = 1'b0;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda_oe = 1'b1;
    tick();
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    o_sda_oe = 1'b1;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda_oe = 1'b0;
    tick();
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(mack, s);
    ack = !s;
  endtask : xfer
  // only mapped offsets are ever written
  task automatic wr(input logic [7:0] off, input logic [15:0] v,
                    output logic ok);
    logic [7:0] q;
    logic [3:0] a;
    start();
    xfer({dev_addr, 1'b0}, 1'b1, q, a[0]);
    xfer(off, 1'b1, q, a[1]);
    xfer(v[15:8], 1'b1, q, a[2]);
    xfer(v[7:0], 1'b1, q, a[3]);
    stop();
    ok = &a;
  endtask : wr
  task automatic rd(input logic [7:0] off, output logic [15:0] v);
    logic [7:0] q;
    logic a;
    start();
    xfer({dev_addr, 1'b0}, 1'b1, q, a);
    xfer(off, 1'b1, q, a);
    start();
    xfer({dev_addr, 1'b1}, 1'b1, q, a);
    xfer(8'hFF, 1'b0, v[15:8], a);
    xfer(8'hFF, 1'b1, v[7:0], a);
    stop();
  endtask : rd
endmodule : ldr_host_model
`default_nettype wire

// *** bench/ldr_regfile_tb.sv ***
// testbench: register file driven over the serial bus by a host model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  miscompares++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module ldr_regfile_tb;
  import ldr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pwm = 1'b1;
  logic [7:0] sup = '0, bst = '0, led = '0;
  logic [15:0] live = '0, oduty = '0, bright;
  logic [11:0] ccode = '0, curr;
  logic [9:0] btgt = '0;
  ldr_detect_s det = '0;
  logic scl, host_oe, dut_out, dut_oe, ok;
  logic asel = 1'b0;
  logic [15:0] u1, u2;
  logic [23:0] en, fl;
  wire sda;
  int miscompares = 0, n_compared = 0, cycles = 0;
  // open drain with pull-up
  assign sda = (dut_oe ? dut_out : 1'b1) & ~host_oe;
  always #50 clk = ~clk;
  ldr_host_model host (.i_core_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_sda_oe(host_oe));
  ldr_regfile dut (
    .i_core_clk(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda),
    .i_addr_sel(asel), .i_pwm_in(pwm), .i_supply_fault(sup),
    .i_boost_fault(bst), .i_led_fault(led), .i_live_state_code(live),
    .i_applied_output_duty(oduty), .i_applied_current_code(ccode),
    .i_boost_target_code(btgt), .i_detected(det), .o_sda_out(dut_out),
    .o_sda_oe(dut_oe), .o_brightness_setpoint(bright),
    .o_drive_current_level(curr), .o_user_settings_one(u1),
    .o_user_settings_two(u2), .o_fault_enable(en), .o_fault_flags(fl));
  ////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk_rd(input logic [7:0] off, input logic [15:0] e);
    logic [15:0] v;
    host.rd(off, v);
    `CHK(v, e)
  endtask : chk_rd
  task automatic t_reset_vals();
    logic [15:0] e [10] = '{16'h0000, 16'h0FFF, 16'h08A3, 16'h0100,
      16'hAAAA, 16'hAAAA, 16'hAAAA, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 10; i++) begin
      chk_rd(8'(2 * i), e[i]);
    end
    chk_rd(LDR_OFF_PWM_IN, 16'h0000);
    `CHK(u1, 16'h08A3)
    `CHK(u2, 16'h0100)
  endtask : t_reset_vals
  task automatic t_rw();
    host.wr(LDR_OFF_BRIGHT, 16'hFFFF, ok);
    `CHK(ok, 1'b1)
    `CHK(bright, 16'hFFFF)
    host.wr(LDR_OFF_CURR, 16'hA5C3, ok);
    `CHK(curr, 12'h5C3)
    chk_rd(LDR_OFF_CURR, 16'hA5C3);
    // wrong device address must be ignored
    host.dev_addr = LDR_BUS_ADDR ^ 7'h01;
    host.wr(LDR_OFF_BRIGHT, 16'h1234, ok);
    host.dev_addr = LDR_BUS_ADDR;
    `CHK(ok, 1'b0)
    chk_rd(LDR_OFF_BRIGHT, 16'hFFFF);
    // strap high moves the device to the odd address
    asel = 1'b1;
    host.dev_addr = LDR_BUS_ADDR ^ 7'h01;
    host.wr(LDR_OFF_BRIGHT, 16'h1234, ok);
    `CHK(ok, 1'b1)
    `CHK(bright, 16'h1234)
    chk_rd(LDR_OFF_BRIGHT, 16'h1234);
    asel = 1'b0;
    host.dev_addr = LDR_BUS_ADDR;
    host.wr(LDR_OFF_USER2, 16'h1357, ok);
    `CHK(u2, 16'h1357)
    chk_rd(LDR_OFF_USER2, 16'h1357);
  endtask : t_rw
  task automatic t_diag();
    live = 16'h1234;
    oduty = 16'hBEEF;
    ccode = 12'hABC;
    btgt = 10'h2C5;
    det = ldr_detect_s'(14'h259C);
    host.wr(LDR_OFF_PWM_OUT, 16'h0000, ok);
    host.wr(LDR_OFF_FSM, 16'hFFFF, ok);
    `CHK(bright, 16'h1234)
    chk_rd(LDR_OFF_FSM, 16'h1234);
    chk_rd(LDR_OFF_PWM_OUT, 16'hBEEF);
    chk_rd(LDR_OFF_CURR_DIAG, 16'h0ABC);
    chk_rd(LDR_OFF_BOOST, 16'h02C5);
    chk_rd(LDR_OFF_DETECT, {2'b00, det});
    chk_rd(8'h20, 16'h0000);
    live = 16'h0005;
    chk_rd(LDR_OFF_FSM, 16'h0005);
  endtask : t_diag
  task automatic t_fault();
    sup = 8'h08;
    bst = 8'h80;
    led = 8'h01;
    @(negedge clk);
    sup = '0;
    bst = '0;
    led = '0;
    `CHK(fl, 24'h018008)
    chk_rd(LDR_OFF_SUP_ST, 16'h0040);
    host.wr(LDR_OFF_SUP_ST, 16'h0080, ok);
    host.wr(LDR_OFF_BST_ST, 16'h4000, ok);
    `CHK(fl, 24'h018008)
    host.wr(LDR_OFF_SUP_ST, 16'h00C0, ok);
    host.wr(LDR_OFF_LED_ST, 16'h0003, ok);
    chk_rd(LDR_OFF_BST_ST, 16'h4000);
    `CHK(fl, 24'h008000)
    // a fault held through its clear write must survive it
    led = 8'h02;
    host.wr(LDR_OFF_LED_ST, 16'h000C, ok);
    `CHK(fl, 24'h028000)
    led = '0;
    host.wr(LDR_OFF_LED_ST, 16'h000C, ok);
    `CHK(fl, 24'h008000)
  endtask : t_fault
  task automatic t_enable();
    host.wr(LDR_OFF_BST_EN, 16'h0001, ok);
    `CHK(en, 24'hFFFEFF)
    host.wr(LDR_OFF_BST_EN, 16'h0002, ok);
    chk_rd(LDR_OFF_BST_EN, 16'hAAA8);
    host.wr(LDR_OFF_BST_EN, 16'h0003, ok);
    chk_rd(LDR_OFF_BST_EN, 16'hAAAA);
    `CHK(en, 24'hFFFFFF)
  endtask : t_enable
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset_vals();
    t_rw();
    t_diag();
    t_fault();
    t_enable();
    // pin held high: first 65536-clock window saturates
    wait (cycles > 67000);
    @(negedge clk);
    chk_rd(LDR_OFF_PWM_IN, 16'hFFFF);
    stop_test();
  end
endmodule : ldr_regfile_tb
bind ldr_regfile ldr_regfile_properties u_props (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_scl(i_scl),
  .i_supply_fault(i_supply_fault), .i_boost_fault(i_boost_fault),
  .i_led_fault(i_led_fault), .o_sda_oe(o_sda_oe),
  .o_brightness_setpoint(o_brightness_setpoint),
  .o_drive_current_level(o_drive_current_level),
  .o_fault_enable(o_fault_enable), .o_fault_flags(o_fault_flags));
`default_nettype wire
